// ### hdl/lrsd_decoder.v
// link request stream decoder: serial request intake, pending requests, differentiated pins
// What this block does
// - stream framed by start 1, stop 0
// - one bit per clock, bit 0 first
// - three type bits follow start bit
// - immediate request seizes bus on idle
// - isochronous arbitrates on idle, no gap
// - fair/priority wait subaction gap, fairness differs
// - stream length set by request type, and for bus requests by bit 6
// - speed in bits 4-6, stop optional
// - speed codes S100 S200 S400, others invalid
// - invalid speed accepted, null packet sent
// - read request: address bits 4-7
// - write request: address and eight data bits
// - acceleration control bit 4 enables
// - receive clears fair/priority requests
// - isochronous pending until bus won
// - immediate granted right after packet end
// - differentiate outputs, hysteresis on request input
// - differentiation on while isolation select low
// - differentiated output drives one clock per change
// - control codes idle status receive grant
// - new bus request ignored while pending
`timescale 1ns/100ps
`include "lrsd_map.vh"
module lrsd_decoder (
  input  wire       clk,
  input  wire       reset,
  input  wire [7:0] busAddr,
  input  wire [7:0] busWrData,
  input  wire       busWrite,
  input  wire       busRead,
  output reg  [7:0] busRdData_r,
  input  wire       linkRequestLine,
  input  wire       linkRequestDriven,
  input  wire       isoSelect,
  input  wire       phyOwnsCtl,
  input  wire [1:0] phyCtlCode,
  input  wire [7:0] phyDataOut,
  input  wire       busIdle,
  input  wire       subactionGap,
  input  wire       arbWon,
  input  wire       packetEnd,
  input  wire       busReset,
  input  wire       enhanceAllowed,
  input  wire       regReadDone,
  output wire [1:0] ifaceControlOut,
  output wire [1:0] ifaceControlOe,
  output wire [7:0] ifaceDataOut,
  output wire [7:0] ifaceDataOe,
  output reg        seizeBus_r,
  output reg        arbStart_r,
  output reg        arbFollowFair_r,
  output reg  [2:0] reqSpeed_r,
  output reg        sendNullPacket_r,
  output reg        accelEnable_r,
  output reg        regReadPending_r,
  output reg  [3:0] regReadAddr_r,
  output wire [7:0] regReadData
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_SHIFT = 2'h1;

  // two-stage synchronisers, then a keeper that acts as the hysteresis input
  reg [1:0] lreqSync_r;
  reg [1:0] drvSync_r;
  reg [1:0] isoSync_r;
  reg       lreqLevel_r;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      lreqSync_r  <= 2'h0;
      drvSync_r   <= 2'h0;
      isoSync_r   <= 2'h3;
      lreqLevel_r <= 1'b0;
    end else begin
      lreqSync_r <= {lreqSync_r[0], linkRequestLine};
      drvSync_r  <= {drvSync_r[0], linkRequestDriven};
      isoSync_r  <= {isoSync_r[0], isoSelect};
      if (drvSync_r[1]) begin
        lreqLevel_r <= lreqSync_r[1];
      end
    end
  end

  wire reqBit = lreqLevel_r;
  wire diffOn = ~isoSync_r[1];

  reg  [1:0]  state_r;
  reg  [4:0]  bitCnt_r;
  reg  [15:0] shift_r;
  reg         rxHit_r;
  reg  [2:0]  typeHeld_r;
  reg  [1:0]  ctrl_r;
  reg  [15:0] lastReq_r;
  reg         busPend_r;
  reg  [2:0]  busType_r;
  reg  [1:0]  ctlCode_r;
  reg         ctlDrive_r;
  reg  [7:0]  dataLvl_r;

  wire [2:0]  curType = (bitCnt_r == `LRSD_LEN_TYPE) ? shift_r[2:0] : typeHeld_r;
  wire [15:0] nextShift = {shift_r[14:0], reqBit};
  wire        ownReceive = phyOwnsCtl && (phyCtlCode == `LRSD_CTL_RECEIVE);
  wire        isFairPri = (curType == `LRSD_TYPE_PRI) || (curType == `LRSD_TYPE_FAIR);

  // stream length once the type is known; short bus form ends when bit 6 is 0
  reg  [4:0] streamLen;
  always @* begin
    case (curType)
      `LRSD_TYPE_REGISTER_READ_REQUEST: streamLen = `LRSD_LEN_REGISTER_READ_REQUEST;
      `LRSD_TYPE_REGISTER_WRITE_REQUEST: streamLen = `LRSD_LEN_REGISTER_WRITE_REQUEST;
      `LRSD_TYPE_ACCEL: streamLen = `LRSD_LEN_ACCEL;
      default:          streamLen = `LRSD_LEN_BUS;
    endcase
  end

  wire isBus = ~curType[2];
  wire shortBusEnd = isBus && (bitCnt_r == `LRSD_LEN_BUS_SHORT) && (shift_r[0] == 1'b0);
  wire lastBit = (bitCnt_r == streamLen - 5'h01);
  wire doneNow = (state_r == ST_SHIFT) && (lastBit || shortBusEnd);
  wire stopOk = shortBusEnd || !ctrl_r[`LRSD_CTRL_STOPCHK] || (reqBit == 1'b0);
  wire accept = doneNow && stopOk;

  // field positions in the finished word: shift_r holds bits 1..n-2 at the end
  // bus: type[5:3], speed[2:0]; the short form ends at the same count
  wire [2:0] endType = curTypeAt(bitCnt_r, shift_r);
  wire [2:0] speedFld = shortBusEnd ? shift_r[2:0] : shift_r[2:0];

  function [2:0] curTypeAt;
    input [4:0]  n;
    input [15:0] s;
    begin
      // bits held = n-1; type is the oldest three of them
      case (n)
        `LRSD_LEN_ACCEL - 5'h01: curTypeAt = s[3:1];
        `LRSD_LEN_BUS - 5'h01:   curTypeAt = s[5:3];
        `LRSD_LEN_REGISTER_READ_REQUEST - 5'h01: curTypeAt = s[6:4];
        `LRSD_LEN_REGISTER_WRITE_REQUEST - 5'h01: curTypeAt = s[14:12];
        default:                 curTypeAt = s[2:0];
      endcase
    end
  endfunction

  wire isRd = accept && (endType == `LRSD_TYPE_REGISTER_READ_REQUEST);
  wire isWr = accept && (endType == `LRSD_TYPE_REGISTER_WRITE_REQUEST);
  wire isAc = accept && (endType == `LRSD_TYPE_ACCEL);
  wire isBr = accept && !endType[2];
  wire brDrop = rxHit_r || (ownReceive && (endType[2:1] == 2'h1));

  // intake: one sample per clock, most significant first
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r  <= ST_IDLE;
      bitCnt_r <= 5'h00;
      shift_r  <= 16'h0000;
      rxHit_r  <= 1'b0;
      typeHeld_r <= 3'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          rxHit_r <= 1'b0;
          shift_r <= 16'h0000;
          if (reqBit && ctrl_r[`LRSD_CTRL_DEC_EN]) begin
            state_r  <= ST_SHIFT;
            bitCnt_r <= 5'h01;
          end
        end
        ST_SHIFT: begin
          shift_r  <= doneNow ? shift_r : nextShift;
          bitCnt_r <= bitCnt_r + 5'h01;
          // hold type bits once shifted in
          if (bitCnt_r == `LRSD_LEN_TYPE) begin
            typeHeld_r <= shift_r[2:0];
          end
          if (bitCnt_r > `LRSD_LEN_TYPE - 5'h01 && isFairPri && ownReceive) begin
            rxHit_r <= 1'b1;
          end
          if (doneNow || (bitCnt_r == `LRSD_LEN_TYPE && curType == `LRSD_TYPE_RSVD)) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // pending requests and arbitration control
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      busPend_r        <= 1'b0;
      busType_r        <= 3'h0;
      reqSpeed_r       <= 3'h0;
      sendNullPacket_r <= 1'b0;
      seizeBus_r       <= 1'b0;
      arbStart_r       <= 1'b0;
      arbFollowFair_r  <= 1'b0;
      accelEnable_r    <= 1'b1;
      regReadPending_r <= 1'b0;
      regReadAddr_r    <= 4'h0;
      lastReq_r        <= 16'h0000;
    end else begin
      seizeBus_r <= 1'b0;
      arbStart_r <= 1'b0;
      if (accept) begin
        lastReq_r <= shift_r;
      end
      if (busReset) begin
        busPend_r        <= 1'b0;
        sendNullPacket_r <= 1'b0;
      end else if (busPend_r) begin
        case (busType_r)
          `LRSD_TYPE_IMM: if (busIdle || packetEnd) begin
            seizeBus_r <= 1'b1;
            busPend_r  <= 1'b0;
          end
          `LRSD_TYPE_ISO: begin
            arbStart_r <= busIdle;
            if (arbWon) begin
              busPend_r <= 1'b0;
            end
          end
          default: begin
            arbStart_r      <= subactionGap && !ownReceive;
            arbFollowFair_r <= (busType_r == `LRSD_TYPE_FAIR);
            if (arbWon || ownReceive) begin
              busPend_r <= 1'b0;
            end
          end
        endcase
      // new bus request ignored while pending
      end else if (isBr && !brDrop) begin
        busPend_r  <= 1'b1;
        busType_r  <= endType;
        reqSpeed_r <= speedFld;
        sendNullPacket_r <= !(speedFld == `LRSD_SPD_S100 || speedFld == `LRSD_SPD_S200 ||
                              speedFld == `LRSD_SPD_S400);
      end
      if (isAc) begin
        accelEnable_r <= shift_r[0];
      end else if (busReset || (isBr && endType == `LRSD_TYPE_ISO && !busPend_r)) begin
        accelEnable_r <= enhanceAllowed;
      end
      // read address; set wins over done
      if (isRd && !regReadPending_r) begin
        regReadPending_r <= 1'b1;
        regReadAddr_r    <= shift_r[3:0];
      end else if (regReadDone) begin
        regReadPending_r <= 1'b0;
      end
    end
  end

  lrsd_reg_mem u_mem (
    .clk      (clk),
    .reset    (reset),
    .wrEn     (isWr),
    .wrAddr   (shift_r[11:8]),
    .wrData   (shift_r[7:0]),
    .rdAddr   (regReadAddr_r),
    .rdData_r (regReadData)
  );

  // control pair drive; grant overrides the phy's own code after a received packet
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctlCode_r  <= `LRSD_CTL_IDLE;
      ctlDrive_r <= 1'b1;
      dataLvl_r  <= 8'h00;
    end else begin
      ctlDrive_r <= phyOwnsCtl;
      dataLvl_r  <= phyDataOut;
      if (busPend_r && busType_r == `LRSD_TYPE_IMM && packetEnd) begin
        ctlCode_r <= `LRSD_CTL_GRANT;
      end else begin
        ctlCode_r <= phyOwnsCtl ? phyCtlCode : `LRSD_CTL_IDLE;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_pin
      wire lvl = (gi < 2) ? ctlCode_r[gi % 2] : dataLvl_r[(gi + 6) % 8];
      wire pOut;
      wire pOe;
      lrsd_diff_out u_diff (
        .clk      (clk),
        .reset    (reset),
        .diffOn   (diffOn),
        .level    (lvl),
        .drive    (ctlDrive_r),
        .pinOut_r (pOut),
        .pinOe_r  (pOe)
      );
      if (gi < 2) begin : g_ctl
        assign ifaceControlOut[gi] = pOut;
        assign ifaceControlOe[gi]  = pOe;
      end else begin : g_dat
        assign ifaceDataOut[gi-2] = pOut;
        assign ifaceDataOe[gi-2]  = pOe;
      end
    end
  endgenerate

  // software registers
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r      <= `LRSD_CTRL_RESET;
      busRdData_r <= 8'h00;
    end else begin
      if (busWrite && busAddr == `LRSD_ADDR_CTRL) begin
        ctrl_r <= busWrData[1:0];
      end
      busRdData_r <= 8'h00;
      if (busRead) begin
        case (busAddr)
          `LRSD_ADDR_CTRL:   busRdData_r <= {6'h00, ctrl_r};
          `LRSD_ADDR_STATUS: busRdData_r <= {busPend_r, busType_r, regReadPending_r,
                                             accelEnable_r, sendNullPacket_r, state_r[0]};
          `LRSD_ADDR_LAST:   busRdData_r <= lastReq_r[7:0];
          default:           busRdData_r <= 8'h00;
        endcase
      end
    end
  end

endmodule // lrsd_decoder

// ### hdl/lrsd_map.vh
// constants for the link request stream decoder
`ifndef LRSD_MAP_VH
`define LRSD_MAP_VH

// request type codes
`define LRSD_TYPE_IMM     3'h0
`define LRSD_TYPE_ISO     3'h1
`define LRSD_TYPE_PRI     3'h2
`define LRSD_TYPE_FAIR    3'h3
`define LRSD_TYPE_REGISTER_READ_REQUEST   3'h4
`define LRSD_TYPE_REGISTER_WRITE_REQUEST   3'h5
`define LRSD_TYPE_ACCEL   3'h6
`define LRSD_TYPE_RSVD    3'h7

// speed codes
`define LRSD_SPD_S100     3'h0
`define LRSD_SPD_S200     3'h2
`define LRSD_SPD_S400     3'h4

// stream lengths in bits, start and stop included except the short bus form and the type count
`define LRSD_LEN_BUS      5'h08
`define LRSD_LEN_BUS_SHORT 5'h07
`define LRSD_LEN_REGISTER_READ_REQUEST    5'h09
`define LRSD_LEN_REGISTER_WRITE_REQUEST    5'h11
`define LRSD_LEN_ACCEL    5'h06
`define LRSD_LEN_TYPE     5'h04

// control pair codes while the device owns it
`define LRSD_CTL_IDLE     2'h0
`define LRSD_CTL_STATUS   2'h1
`define LRSD_CTL_RECEIVE  2'h2
`define LRSD_CTL_GRANT    2'h3

// software register byte addresses
`define LRSD_ADDR_CTRL    8'h00
`define LRSD_ADDR_STATUS  8'h04
`define LRSD_ADDR_LAST    8'h08

// control register fields and reset value
`define LRSD_CTRL_DEC_EN  0
`define LRSD_CTRL_STOPCHK 1
`define LRSD_CTRL_RESET   2'h3

// memory shape
`define LRSD_MEM_AW       4
`define LRSD_MEM_DW       8

`endif

// ### hdl/lrsd_diff_out.v
// one differentiated three-state output bit
`timescale 1ns/100ps
module lrsd_diff_out (
  input  wire clk,
  input  wire reset,
  input  wire diffOn,
  input  wire level,
  input  wire drive,
  output reg  pinOut_r,
  output reg  pinOe_r
);

  reg prevLevel_r;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      prevLevel_r <= 1'b0;
      pinOut_r    <= 1'b0;
      pinOe_r     <= 1'b0;
    end else begin
      prevLevel_r <= level;
      pinOut_r    <= level;
      // isolation keeps the old level, so only edges need driving
      if (diffOn) begin
        pinOe_r <= drive && (level != prevLevel_r);
      end else begin
        pinOe_r <= drive;
      end
    end
  end

endmodule // lrsd_diff_out

// ### hdl/lrsd_reg_mem.v
// small register store with registered read data
`timescale 1ns/100ps
`include "lrsd_map.vh"
module lrsd_reg_mem (
  input  wire                        clk,
  input  wire                        reset,
  input  wire                        wrEn,
  input  wire [`LRSD_MEM_AW-1:0]     wrAddr,
  input  wire [`LRSD_MEM_DW-1:0]     wrData,
  input  wire [`LRSD_MEM_AW-1:0]     rdAddr,
  output reg  [`LRSD_MEM_DW-1:0]     rdData_r
);

  reg [`LRSD_MEM_DW-1:0] store [0:(1<<`LRSD_MEM_AW)-1];

  always @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData_r <= {`LRSD_MEM_DW{1'b0}};
    end else begin
      rdData_r <= store[rdAddr];
    end
  end

endmodule // lrsd_reg_mem

// ### testbench/lrsd_decoder_props.sv
// port checker for the link request stream decoder
`timescale 1ns/100ps
module lrsd_decoder_props (
  input wire       clk,
  input wire       reset,
  input wire       busRead,
  input wire [7:0] busRdData_r,
  input wire       isoSelect,
  input wire       phyOwnsCtl,
  input wire [1:0] phyCtlCode,
  input wire       busIdle,
  input wire       subactionGap,
  input wire       packetEnd,
  input wire [1:0] ifaceControlOut,
  input wire [1:0] ifaceControlOe,
  input wire [7:0] ifaceDataOe,
  input wire       seizeBus_r,
  input wire       arbStart_r,
  input wire       sendNullPacket_r,
  input wire [2:0] reqSpeed_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire [3:0] ctlIn = {isoSelect, phyOwnsCtl, phyCtlCode};
  reg  [2:0] up_r;
  // the pin pipeline still carries reset-time values for a few edges
  always @(posedge clk or posedge reset) begin
    if (reset)
      up_r <= 3'h0;
    else if (up_r != 3'h7)
      up_r <= up_r + 3'h1;
  end
  sequence s_calm;
    up_r == 3'h7 && ctlIn == $past(ctlIn) && ctlIn == $past(ctlIn, 2) && ctlIn == $past(ctlIn, 3)
      && ctlIn == $past(ctlIn, 4);
  endsequence
  property p_diffQuiet;
    s_calm and !isoSelect |-> ifaceControlOe == 2'h0 && ifaceDataOe == 8'h00;
  endproperty
  property p_diffOff;
    s_calm and isoSelect && phyOwnsCtl |-> ifaceControlOe == 2'h3 && ifaceDataOe == 8'hff;
  endproperty
  property p_ctlCode;
    s_calm and isoSelect && phyOwnsCtl && !$past(packetEnd, 2) |-> ifaceControlOut == phyCtlCode;
  endproperty
  property p_grant;
    seizeBus_r && $past(packetEnd) |=> ifaceControlOut == 2'h3;
  endproperty
  property p_seize;
    seizeBus_r |-> $past(busIdle) || $past(packetEnd) || $past(busIdle, 2) || $past(packetEnd, 2);
  endproperty
  property p_pulse;
    seizeBus_r |=> !seizeBus_r;
  endproperty
  property p_null;
    sendNullPacket_r |-> reqSpeed_r != 3'h0 && reqSpeed_r != 3'h2 && reqSpeed_r != 3'h4;
  endproperty
  property p_arb;
    arbStart_r |-> $past(busIdle) || $past(subactionGap) || $past(busIdle, 2) || $past(subactionGap, 2);
  endproperty
  property p_rdData;
    busRdData_r != 8'h00 |-> $past(busRead);
  endproperty
  a_diffQuiet: assert property (p_diffQuiet) else $error("pin driven while level steady");
  a_diffOff: assert property (p_diffOff) else $error("pins not driven while owned");
  a_ctlCode: assert property (p_ctlCode) else $error("control pair code differs");
  a_seize: assert property (p_seize) else $error("seize without idle or packet end");
  a_pulse: assert property (p_pulse) else $error("seize longer than one cycle");
  a_grant: assert property (p_grant) else $error("grant missing after packet end");
  a_null: assert property (p_null) else $error("null packet for a valid speed");
  a_arb: assert property (p_arb) else $error("arbitration without idle or gap");
  a_rdData: assert property (p_rdData) else $error("read data without read strobe");
  c_seize: cover property (seizeBus_r);
  c_arb: cover property (arbStart_r);
  c_quiet: cover property (s_calm and !isoSelect);
endmodule // lrsd_decoder_props

bind lrsd_decoder lrsd_decoder_props u_props (
  .clk(clk), .reset(reset), .busRead(busRead), .busRdData_r(busRdData_r), .isoSelect(isoSelect),
  .phyOwnsCtl(phyOwnsCtl), .phyCtlCode(phyCtlCode), .busIdle(busIdle), .subactionGap(subactionGap),
  .packetEnd(packetEnd), .ifaceControlOut(ifaceControlOut), .ifaceControlOe(ifaceControlOe),
  .ifaceDataOe(ifaceDataOe), .seizeBus_r(seizeBus_r), .arbStart_r(arbStart_r),
  .sendNullPacket_r(sendNullPacket_r), .reqSpeed_r(reqSpeed_r)
);

// ### testbench/lrsd_link_model.sv
// link-side controller model shifting request streams onto the request line
`timescale 1ns/100ps
module lrsd_link_model (
  input  wire clk,
  input  wire isoSel,
  output wire reqLine,
  output reg  reqDriven
);
  reg val = 1'b0;
  initial reqDriven = 1'b1;
  // undriven line shows the inverse so only the input keeper can save it
  assign reqLine = reqDriven ? val : ~val;
  // start first, rests low, driven on change
  task send(input [16:0] bits, input [4:0] len);
    integer i;
    reg     b;
    begin
      for (i = 0; i < len + 3; i = i + 1) begin
        b = (i < len) ? bits[len - 1 - i] : 1'b0;
        @(posedge clk);
        reqDriven <= isoSel | (b != val);
        val <= b;
      end
    end
  endtask
endmodule // lrsd_link_model

// ### testbench/link_request_stream_decoder_test.sv
// self-checking bench for the link request stream decoder
`timescale 1ns/100ps
module link_request_stream_decoder_test;
  reg        clk = 1'b0;
  reg        reset = 1'b1;
  reg  [7:0] busAddr = 8'h00;
  reg  [7:0] busWrData = 8'h00;
  reg        busWrite = 1'b0;
  reg        busRead = 1'b0;
  reg        isoSelect = 1'b1;
  reg        phyOwnsCtl = 1'b1;
  reg  [1:0] phyCtlCode = 2'h0;
  // regReadDone, busReset, packetEnd, arbWon, subactionGap, busIdle
  reg  [5:0] evt = 6'h00;
  wire [7:0] rdBus, datOut, datOe, rdData;
  wire [1:0] ctlOut, ctlOe;
  wire [2:0] speed;
  wire [3:0] rdAddr;
  wire       link_request_line, ldrv, seize, arb, fair, nul, accel, rdPend;
  integer    num_errors = 0;
  integer    check_count = 0;
  integer    cycles = 0;
  reg  [7:0] q, q0, q1;
  reg  [1:0] hit;
  always #10 clk = ~clk;
  lrsd_link_model lm (.clk(clk), .isoSel(isoSelect), .reqLine(link_request_line), .reqDriven(ldrv));
  lrsd_decoder dut (
    .clk(clk), .reset(reset), .busAddr(busAddr), .busWrData(busWrData), .busWrite(busWrite),
    .busRead(busRead), .busRdData_r(rdBus), .linkRequestLine(link_request_line), .linkRequestDriven(ldrv),
    .isoSelect(isoSelect), .phyOwnsCtl(phyOwnsCtl), .phyCtlCode(phyCtlCode), .phyDataOut(8'h5a),
    .busIdle(evt[0]), .subactionGap(evt[1]), .arbWon(evt[2]), .packetEnd(evt[3]), .busReset(evt[4]),
    .enhanceAllowed(1'b1), .regReadDone(evt[5]), .ifaceControlOut(ctlOut), .ifaceControlOe(ctlOe),
    .ifaceDataOut(datOut), .ifaceDataOe(datOe), .seizeBus_r(seize), .arbStart_r(arb),
    .arbFollowFair_r(fair), .reqSpeed_r(speed), .sendNullPacket_r(nul), .accelEnable_r(accel),
    .regReadPending_r(rdPend), .regReadAddr_r(rdAddr), .regReadData(rdData)
  );
  task chk(input [8*8-1:0] name, input [7:0] exp, input [7:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task acc(input wr, input [7:0] a, input [7:0] d, output reg [7:0] r);
    begin
      @(posedge clk);
      busAddr <= a;
      busWrData <= d;
      busWrite <= wr;
      busRead <= !wr;
      @(posedge clk);
      busWrite <= 1'b0;
      busRead <= 1'b0;
      #1 r = rdBus;
    end
  endtask
  task req(input [16:0] b, input [4:0] n);
    begin
      lm.send(b, n);
      repeat (6) @(posedge clk);
    end
  endtask
  task pulse(input integer k, output reg [1:0] h);
    integer i;
    begin
      h = 2'b00;
      @(posedge clk);
      evt[k] <= 1'b1;
      @(posedge clk);
      evt[k] <= 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
        #1 h = h | {arb, seize};
        @(posedge clk);
      end
    end
  endtask
  task t_regs;
    begin
      acc(1'b0, 8'h00, 8'h00, q);
      chk("ctrl", 8'h03, q);
      acc(1'b1, 8'h00, 8'h03, q);
      acc(1'b0, 8'h20, 8'h00, q);
      chk("unmapped", 8'h00, q);
      chk("accelRst", 8'h01, 8'(accel));
      $display("test regs done");
    end
  endtask
  task t_accel;
    begin
      req(17'h00038, 5'd6);
      chk("accel", 8'h00, 8'(accel));
      req(17'h0003a, 5'd6);
      chk("accel", 8'h01, 8'(accel));
      $display("test accel done");
    end
  endtask
  task t_regfile;
    begin
      req(17'h1a74a, 5'd17);
      req(17'h00186, 5'd9);
      chk("rdPend", 8'h01, 8'(rdPend));
      chk("rdAddr", 8'h03, 8'(rdAddr));
      chk("rdData", 8'ha5, rdData);
      acc(1'b0, 8'h04, 8'h00, q);
      chk("stRead", 8'h01, 8'(q[3]));
      pulse(5, hit);
      chk("rdPend", 8'h00, 8'(rdPend));
      $display("test regfile done");
    end
  endtask
  task t_fair;
    begin
      // interface idle for many clocks before the request
      req(17'h000b4, 5'd8);
      chk("speed", 8'h02, 8'(speed));
      chk("fair", 8'h01, 8'(fair));
      acc(1'b0, 8'h04, 8'h00, q);
      chk("busPend", 8'h01, 8'(q[7]));
      @(posedge clk);
      phyCtlCode <= 2'h2;
      repeat (2) @(posedge clk);
      phyCtlCode <= 2'h0;
      repeat (4) @(posedge clk);
      acc(1'b0, 8'h04, 8'h00, q);
      chk("busPend", 8'h00, 8'(q[7]));
      pulse(1, hit);
      chk("arbStart", 8'h00, 8'(hit[1]));
      $display("test fair done");
    end
  endtask
  task t_iso;
    begin
      // a cycle start is taken as seen; next idle has passed
      req(17'h00096, 5'd8);
      chk("null", 8'h01, 8'(nul));
      req(17'h000b0, 5'd8);
      chk("speed", 8'h03, 8'(speed));
      pulse(0, hit);
      chk("arbStart", 8'h01, 8'(hit[1]));
      acc(1'b0, 8'h04, 8'h00, q);
      chk("busPend", 8'h01, 8'(q[7]));
      pulse(2, hit);
      acc(1'b0, 8'h04, 8'h00, q);
      chk("busPend", 8'h00, 8'(q[7]));
      $display("test iso done");
    end
  endtask
  task t_imm;
    begin
      @(posedge clk);
      phyCtlCode <= 2'h2;
      // short immediate request sent during reception
      req(17'h00044, 5'd7);
      chk("ctlOut", 8'h02, 8'(ctlOut));
      pulse(3, hit);
      chk("seize", 8'h01, 8'(hit[0]));
      phyCtlCode <= 2'h3;
      repeat (6) @(posedge clk);
      chk("ctlOut", 8'h03, 8'(ctlOut));
      // bad header: controller hands the interface straight back
      phyCtlCode <= 2'h0;
      repeat (6) @(posedge clk);
      chk("ctlOut", 8'h00, 8'(ctlOut));
      $display("test imm done");
    end
  endtask
  task t_pri;
    begin
      // receive shows for one cycle just after the type bits have been shifted in
      fork
        lm.send(17'h00050, 5'd7);
        begin
          repeat (8) @(posedge clk);
          phyCtlCode <= 2'h2;
          @(posedge clk);
          phyCtlCode <= 2'h0;
        end
      join
      repeat (6) @(posedge clk);
      acc(1'b0, 8'h04, 8'h00, q);
      chk("busPend", 8'h00, 8'(q[7]));
      req(17'h00050, 5'd7);
      acc(1'b0, 8'h04, 8'h00, q);
      chk("pending", 8'h0a, 8'(q[7:4]));
      chk("fair", 8'h00, 8'(fair));
      pulse(4, hit);
      acc(1'b0, 8'h04, 8'h00, q);
      chk("busPend", 8'h00, 8'(q[7]));
      $display("test pri done");
    end
  endtask
  task t_rsvd;
    begin
      acc(1'b0, 8'h04, 8'h00, q0);
      acc(1'b0, 8'h08, 8'h00, q1);
      req(17'h000f0, 5'd8);
      acc(1'b0, 8'h04, 8'h00, q);
      chk("status", q0, q);
      acc(1'b0, 8'h08, 8'h00, q);
      chk("last", q1, q);
      $display("test rsvd done");
    end
  endtask
  task t_diff;
    integer i, n;
    begin
      n = 0;
      @(posedge clk);
      isoSelect <= 1'b0;
      repeat (8) @(posedge clk);
      phyCtlCode <= 2'h1;
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge clk);
        #1 n = n + (ctlOe != 2'h0);
      end
      chk("oeCycles", 8'h01, 8'(n));
      chk("datOut", 8'h5a, datOut);
      // request line now only driven on change, keeper must hold the level
      req(17'h00038, 5'd6);
      chk("accel", 8'h00, 8'(accel));
      $display("test diff done");
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs;
    t_accel;
    t_regfile;
    t_fair;
    t_iso;
    t_imm;
    t_pri;
    t_rsvd;
    t_diff;
    finish_test;
  end
endmodule // link_request_stream_decoder_test
